/* design/act_clock_tree.sv */
// Audio clock tree: root mux, dividers, PLL control, AHB registers
`timescale 1ns/1ps
module act_clock_tree
    import act_pkg::*;
#(
    // Lock wait in cycles; shorten in simulation
    parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Clock pins; inputs asynchronous to clk, outputs registered on clk
    input wire logic mclk,
    input wire logic bclkIn,
    output logic bclkOut,
    output logic bclkOe_n,
    input wire logic gpioIn,
    output logic gpioOut,
    output logic gpioOe_n,
    // Analog PLL macro
    input wire logic pllClk,
    output act_pll_cfg_s pllCfg,
    output logic pllReady,
    // Clock enables for the DAC core
    output logic dspTick,
    output logic modTick,
    output logic fsTick
);

    // Current and next state
    act_state_s st;
    act_state_s next_st;

    // Synchroniser stages two and three agree
    logic [3:0] agree;
    // Rising edge of each agreed pin level
    logic [3:0] rise;
    // Rising edge of the selected root clock
    logic rootRise;
    // Source edges of the two output dividers
    logic bSrc;
    logic gSrc;
    // Address phase taken this cycle
    logic addrOk;
    // Address falls inside the map window
    logic mapped;
    // Register byte selected for a read
    logic [7:0] rdByte;

    // Edge detection only looks at stages two and three
    assign agree = ~(st.s2 ^ st.s3);
    assign rise = agree & st.s2 & ~st.lvl;

    always_comb begin
        case (st.rootSel)
            2'h0: rootRise = rise[0];
            2'h1: rootRise = rise[1];
            2'h2: rootRise = rise[2];
            // PLL edges are withheld until lock time has passed
            default: rootRise = rise[3] & st.pllReady;
        endcase
    end

    always_comb begin
        case (st.bSel)
            2'h1: bSrc = st.modTick;
            // Codes 0, 2 and 3 all take the DSP clock
            default: bSrc = st.dspTick;
        endcase
    end

    always_comb begin
        case (st.gpSel)
            3'h0: gSrc = rootRise;
            3'h1: gSrc = rise[3] & st.pllReady;
            3'h2: gSrc = st.dspTick;
            3'h3: gSrc = st.modTick;
            3'h4: gSrc = st.fsTick;
            // Unused codes give no clock
            default: gSrc = 1'b0;
        endcase
    end

    // Bus decode: single word transfers, no wait states
    assign addrOk = hsel & htrans[1] & hready;
    assign mapped = (haddr[31:8] == 24'h000000);

    // Read data mux; unmapped indexes read zero
    always_comb begin
        case (haddr[7:2])
            IDX_ROOT_SEL: rdByte = {6'h00, st.rootSel};
            IDX_PLL_CTRL: rdByte = {st.pll.en, st.pll.p, st.pll.r};
            IDX_PLL_J: rdByte = {2'h0, st.pll.j};
            IDX_FRAC_HI: rdByte = {2'h0, st.fracUp};
            IDX_FRAC_LO: rdByte = st.pll.d[7:0];
            IDX_NDIV: rdByte = {st.nEn, st.nVal};
            IDX_MDIV: rdByte = {st.mEn, st.mVal};
            IDX_OSR_HI: rdByte = {6'h00, st.osrHi};
            IDX_OSR_LO: rdByte = st.osrLo;
            IDX_GP_SEL: rdByte = {5'h00, st.gpSel};
            IDX_GP_DIV: rdByte = {1'b0, st.gpDiv};
            IDX_PIN_CTRL: rdByte = {4'h0, st.bclkDrv, 2'h0, st.gpioDrv};
            IDX_B_SEL: rdByte = {6'h00, st.bSel};
            IDX_B_DIV: rdByte = {1'b0, st.bDiv};
            // Live power state of the DAC channel
            IDX_PWR_STAT: rdByte = {st.dacOn, 3'h0, st.modOn, 3'h0};
            IDX_PWR_CTRL: rdByte = {st.dacReq, 7'h00};
            default: rdByte = 8'h00;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        next_st = st;

        // Three-stage pin synchronisers
        next_st.s1 = {pllClk, gpioIn, bclkIn, mclk};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A level counts once stages two and three agree
        next_st.lvl = (agree & st.s2) | (~agree & st.lvl);

        // Ticks are one-cycle pulses
        next_st.dspTick = 1'b0;
        next_st.modTick = 1'b0;
        next_st.fsTick = 1'b0;
        next_st.bclkOut = 1'b0;
        next_st.gpioOut = 1'b0;

        if (rootRise && st.nEn) begin
            if (st.nCnt == st.nVal - 7'h01) begin
                next_st.nCnt = 7'h00;
                next_st.dspTick = 1'b1;
                if (st.mEn) begin
                    if (st.mCnt == st.mVal - 7'h01) begin
                        next_st.mCnt = 7'h00;
                        next_st.modTick = 1'b1;
                        if (st.osrCnt == {st.osrHi, st.osrLo} - 10'h001) begin
                            next_st.osrCnt = 10'h000;
                            next_st.fsTick = 1'b1;
                        end else begin
                            next_st.osrCnt = st.osrCnt + 10'h001;
                        end
                    end else begin
                        next_st.mCnt = st.mCnt + 7'h01;
                    end
                end
            end else begin
                next_st.nCnt = st.nCnt + 7'h01;
            end
        end
        // Disabled dividers restart from a clean phase
        if (!st.nEn) begin
            next_st.nCnt = 7'h00;
        end
        if (!st.mEn) begin
            next_st.mCnt = 7'h00;
            next_st.osrCnt = 10'h000;
        end

        if (bSrc) begin
            if (st.bCnt == st.bDiv - 7'h01) begin
                next_st.bCnt = 7'h00;
                next_st.bclkOut = st.bclkDrv;
            end else begin
                next_st.bCnt = st.bCnt + 7'h01;
            end
        end

        if (gSrc) begin
            if (st.gCnt == st.gpDiv - 7'h01) begin
                next_st.gCnt = 7'h00;
                next_st.gpioOut = st.gpioDrv;
            end else begin
                next_st.gCnt = st.gCnt + 7'h01;
            end
        end

        if (!st.pll.en) begin
            next_st.lockCnt = 18'h00000;
            next_st.pllReady = 1'b0;
        end else if (st.lockCnt == 18'(PLL_LOCK_CYCLES - 1)) begin
            next_st.pllReady = 1'b1;
        end else begin
            next_st.lockCnt = st.lockCnt + 18'h00001;
        end

        case (st.pwr)
            PWR_OFF: begin
                if (st.dacReq && st.nEn && st.mEn) begin
                    next_st.pwr = PWR_ON;
                    next_st.dacOn = 1'b1;
                    next_st.modOn = 1'b1;
                end
            end
            PWR_ON: begin
                if (!st.dacReq) begin
                    next_st.pwr = PWR_SHUT_DAC;
                    next_st.shutCnt = 4'h0;
                end
            end
            PWR_SHUT_DAC: begin
                if (st.modTick) begin
                    if (st.shutCnt == SHUT_TICKS - 4'h1) begin
                        next_st.shutCnt = 4'h0;
                        next_st.dacOn = 1'b0;
                        next_st.pwr = PWR_SHUT_MOD;
                    end else begin
                        next_st.shutCnt = st.shutCnt + 4'h1;
                    end
                end
            end
            PWR_SHUT_MOD: begin
                if (st.modTick) begin
                    if (st.shutCnt == SHUT_TICKS - 4'h1) begin
                        next_st.shutCnt = 4'h0;
                        next_st.modOn = 1'b0;
                        next_st.pwr = PWR_OFF;
                    end else begin
                        next_st.shutCnt = st.shutCnt + 4'h1;
                    end
                end
            end
            default: begin
                next_st.pwr = PWR_OFF;
            end
        endcase

        // Address phase: latch index, prefetch read data
        if (addrOk) begin
            next_st.wrPend = hwrite & mapped;
            next_st.wrIdx = haddr[7:2];
            next_st.rdata = (!hwrite && mapped) ? {24'h000000, rdByte} : 32'h00000000;
        end else begin
            next_st.wrPend = 1'b0;
        end

        // Data phase write; unmapped indexes are dropped
        if (st.wrPend) begin
            case (st.wrIdx)
                IDX_ROOT_SEL: next_st.rootSel = hwdata[1:0];
                IDX_PLL_CTRL: begin
                    next_st.pll.en = hwdata[POS_EN];
                    next_st.pll.p = hwdata[6:4];
                    next_st.pll.r = hwdata[3:0];
                end
                IDX_PLL_J: next_st.pll.j = hwdata[5:0];
                IDX_FRAC_HI: next_st.fracUp = hwdata[5:0];
                IDX_FRAC_LO: next_st.pll.d = {st.fracUp, hwdata[7:0]};
                IDX_NDIV: begin
                    next_st.nEn = hwdata[POS_EN];
                    next_st.nVal = hwdata[6:0];
                end
                IDX_MDIV: begin
                    next_st.mEn = hwdata[POS_EN];
                    next_st.mVal = hwdata[6:0];
                end
                IDX_OSR_HI: next_st.osrHi = hwdata[1:0];
                IDX_OSR_LO: next_st.osrLo = hwdata[7:0];
                IDX_GP_SEL: next_st.gpSel = hwdata[2:0];
                IDX_GP_DIV: next_st.gpDiv = hwdata[6:0];
                IDX_PIN_CTRL: begin
                    next_st.bclkDrv = hwdata[POS_BCLK_DRV];
                    next_st.gpioDrv = hwdata[POS_GPIO_DRV];
                end
                IDX_B_SEL: next_st.bSel = hwdata[1:0];
                IDX_B_DIV: next_st.bDiv = hwdata[6:0];
                IDX_PWR_CTRL: next_st.dacReq = hwdata[POS_EN];
                default: begin
                end
            endcase
        end

        // Pulses stop at once when a pin drive is switched off
        next_st.bclkOut = next_st.bclkOut & next_st.bclkDrv;
        next_st.gpioOut = next_st.gpioOut & next_st.gpioDrv;
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.pll.p <= RST_PLL_P;
            st.pll.r <= RST_PLL_R;
            st.pll.j <= RST_PLL_J;
            st.nVal <= RST_DIV;
            st.mVal <= RST_DIV;
            st.osrLo <= RST_OSR_LO;
            st.bDiv <= RST_DIV;
            st.gpDiv <= RST_DIV;
        end else begin
            st <= next_st;
        end
    end

    // Bus answers are always ready and OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;

    // PLL settings to the analog macro
    assign pllCfg = st.pll;
    assign pllReady = st.pllReady;

    // Pin drivers; enables are active low
    assign bclkOut = st.bclkOut;
    assign bclkOe_n = ~st.bclkDrv;
    assign gpioOut = st.gpioOut;
    assign gpioOe_n = ~st.gpioDrv;
    assign dspTick = st.dspTick;
    assign modTick = st.modTick;
    assign fsTick = st.fsTick;

    // Checks, all on clk and disabled in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_root_mclk;
        (st.rootSel == 2'h0 && st.nEn && rise[0] && st.nCnt == st.nVal - 7'h01)
            |=> st.dspTick;
    endproperty
    a_root_mclk: assert property (p_root_mclk)
        else $error("root edge not taken from master clock pin");

    property p_mod_in_dsp;
        st.modTick |-> (st.dspTick && (!st.fsTick || st.modTick));
    endproperty
    a_mod_in_dsp: assert property (p_mod_in_dsp)
        else $error("modulator tick without DSP tick");

    property p_fs_in_mod;
        st.fsTick |-> st.modTick;
    endproperty
    a_fs_in_mod: assert property (p_fs_in_mod)
        else $error("sample tick without modulator tick");

    property p_mdiv_one;
        (st.dspTick && $past(st.mEn) && $past(st.mVal) == 7'h01 && $past(st.mCnt) == 7'h00)
            |-> st.modTick;
    endproperty
    a_mdiv_one: assert property (p_mdiv_one)
        else $error("modulator divider of one skipped a tick");

    property p_frac_hold;
        (st.wrPend && st.wrIdx == IDX_FRAC_HI) |=> $stable(st.pll.d);
    endproperty
    a_frac_hold: assert property (p_frac_hold)
        else $error("fraction changed on upper write");

    property p_frac_apply;
        (st.wrPend && st.wrIdx == IDX_FRAC_LO)
            |=> (st.pll.d == {$past(st.fracUp), $past(hwdata[7:0])});
    endproperty
    a_frac_apply: assert property (p_frac_apply)
        else $error("fraction not applied on lower write");

    property p_off_flags;
        (st.pwr == PWR_OFF) |-> !(st.dacOn || st.modOn);
    endproperty
    a_off_flags: assert property (p_off_flags)
        else $error("power flags set while channel is off");

    property p_stat_ro;
        (st.wrPend && st.wrIdx == IDX_PWR_STAT && st.pwr == PWR_OFF && !st.dacReq)
            |=> !(st.dacOn || st.modOn);
    endproperty
    a_stat_ro: assert property (p_stat_ro)
        else $error("status write disturbed power flags");

    property p_pll_wait;
        $rose(st.pll.en) |-> !st.pllReady [*2];
    endproperty
    a_pll_wait: assert property (p_pll_wait)
        else $error("PLL ready without lock wait");

    property p_bclk_idle;
        !st.bclkDrv |-> (bclkOe_n && !bclkOut);
    endproperty
    a_bclk_idle: assert property (p_bclk_idle)
        else $error("bit clock driven while not selected");

    property p_gpio_idle;
        !st.gpioDrv |-> (gpioOe_n && !gpioOut);
    endproperty
    a_gpio_idle: assert property (p_gpio_idle)
        else $error("GPIO clock driven while not selected");

endmodule : act_clock_tree

/* design/act_pkg.sv */
// Constants, register map and carrier types of the audio clock tree
// Overview of operation
// - Root clock picked by two-bit selector
// - Modulator clock is root over N times M
// - Divider values come from their register fields
// - Device runs shutdown, reports two status flags
// - Bit clock is source over 1 to 128
// - Bit-clock source is DSP or modulator clock
// - GPIO clock is source over 1 to 128
// - GPIO clock source chosen by three-bit mux
// - PLL enable bit; output is input*R*J.D/P
// - PLL factor ranges and reset values
// - P, R, J held in their register fields
// - Fraction is 14 bits over two registers
// - New fraction applies only after lower write
// - PLL output usable about 10 ms later
package act_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [5:0] IDX_ROOT_SEL = 6'h04;
    localparam logic [5:0] IDX_PLL_CTRL = 6'h05;
    localparam logic [5:0] IDX_PLL_J = 6'h06;
    localparam logic [5:0] IDX_FRAC_HI = 6'h07;
    localparam logic [5:0] IDX_FRAC_LO = 6'h08;
    localparam logic [5:0] IDX_NDIV = 6'h0B;
    localparam logic [5:0] IDX_MDIV = 6'h0C;
    localparam logic [5:0] IDX_OSR_HI = 6'h0D;
    localparam logic [5:0] IDX_OSR_LO = 6'h0E;
    localparam logic [5:0] IDX_GP_SEL = 6'h19;
    localparam logic [5:0] IDX_GP_DIV = 6'h1A;
    localparam logic [5:0] IDX_PIN_CTRL = 6'h1B;
    localparam logic [5:0] IDX_B_SEL = 6'h1D;
    localparam logic [5:0] IDX_B_DIV = 6'h1E;
    localparam logic [5:0] IDX_PWR_STAT = 6'h25;
    localparam logic [5:0] IDX_PWR_CTRL = 6'h3F;
    // Single-bit field positions
    localparam int POS_EN = 7;
    localparam int POS_BCLK_DRV = 3;
    localparam int POS_GPIO_DRV = 0;
    localparam int POS_DAC_FLAG = 7;
    localparam int POS_MOD_FLAG = 3;
    // Reset values of the programmable factors
    localparam logic [2:0] RST_PLL_P = 3'h1;
    localparam logic [3:0] RST_PLL_R = 4'h1;
    localparam logic [5:0] RST_PLL_J = 6'h04;
    localparam logic [6:0] RST_DIV = 7'h01;
    localparam logic [7:0] RST_OSR_LO = 8'h80;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int PLL_LOCK_MS = 10;
    localparam int PLL_LOCK_CYC = PLL_LOCK_MS * 1000000 / CLK_PERIOD_NS;
    localparam logic [3:0] SHUT_TICKS = 4'h4;

    // DAC channel power sequence
    typedef enum logic [1:0] {
        PWR_OFF = 2'b00,
        PWR_ON = 2'b01,
        PWR_SHUT_DAC = 2'b10,
        PWR_SHUT_MOD = 2'b11
    } act_pwr_e;

    // Settings handed to the analog PLL
    typedef struct packed {
        logic en;
        logic [2:0] p;
        logic [3:0] r;
        logic [5:0] j;
        logic [13:0] d;
    } act_pll_cfg_s;

    // Whole state of the clock tree
    typedef struct packed {
        logic [3:0] s1, s2, s3, lvl;
        logic [1:0] rootSel;
        act_pll_cfg_s pll;
        logic [5:0] fracUp;
        logic nEn, mEn;
        logic [6:0] nVal, mVal;
        logic [1:0] osrHi;
        logic [7:0] osrLo;
        logic [2:0] gpSel;
        logic [6:0] gpDiv;
        logic [1:0] bSel;
        logic [6:0] bDiv;
        logic bclkDrv, gpioDrv, dacReq;
        logic [6:0] nCnt, mCnt, bCnt, gCnt;
        logic [9:0] osrCnt;
        logic [17:0] lockCnt;
        logic pllReady;
        act_pwr_e pwr;
        logic [3:0] shutCnt;
        logic dacOn, modOn;
        logic wrPend;
        logic [5:0] wrIdx;
        logic [31:0] rdata;
        logic dspTick, modTick, fsTick, bclkOut, gpioOut;
    } act_state_s;
endpackage : act_pkg

/* bench/test_act_clock_tree.sv */
// Self-checking bench for the audio clock tree registers, dividers and power flags
`timescale 1ns/1ps
module test_act_clock_tree
    import act_pkg::*;
;
    // Short lock wait keeps the run brief
    localparam int LOCK = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    // Clock pins, paced from the system clock
    logic mclk = 1'b0;
    logic bclkIn = 1'b0;
    logic gpioIn = 1'b0;
    logic pllClk = 1'b0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, bclkOut, bclkOe_n, gpioOut, gpioOe_n;
    wire logic pllReady, dspTick, modTick, fsTick;
    wire act_pll_cfg_s pllCfg;
    int err_count = 0;
    int total_checks = 0;
    // Free cycle count for the pin clocks
    int tick = 0;
    logic [31:0] rd;
    logic sawHalf;
    // Expected GP periods for sources 0 to 4 at divide by 2
    int gpExp[5] = '{16, 28, 32, 64, 256};

    // System clock, 40 ns period
    initial begin
        forever #20 clk = ~clk;
    end

    // Pin periods of 8, 10, 12 and 14 cycles tell the root sources apart
    // PLL pin inside input range
    always @(posedge clk) begin
        tick <= tick + 1;
        mclk <= (tick % 8) < 4;
        bclkIn <= (tick % 10) < 5;
        gpioIn <= (tick % 12) < 6;
        pllClk <= (tick % 14) < 7;
    end

    act_clock_tree #(.PLL_LOCK_CYCLES(LOCK)) dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mclk(mclk),
        .bclkIn(bclkIn), .bclkOut(bclkOut), .bclkOe_n(bclkOe_n), .gpioIn(gpioIn),
        .gpioOut(gpioOut), .gpioOe_n(gpioOe_n), .pllClk(pllClk), .pllCfg(pllCfg),
        .pllReady(pllReady), .dspTick(dspTick), .modTick(modTick), .fsTick(fsTick)
    );

    // Compare a register or port value
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_reg

    // Compare a measured period in cycles
    task automatic check_per(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            err_count++;
            $display("wrong value at %0t: period %0d expected %0d", $time, got, exp);
        end
    endtask : check_per

    // One AHB single transfer; entered just after a rising edge
    task automatic bus(input logic [5:0] idx, input logic wr, input logic [31:0] wd,
            output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= {24'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        // Address phase held until ready is sampled high
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, {24'h0, d}, rd);
    endtask : wr

    task automatic chk(input logic [5:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 32'h0, rd);
        check_reg(rd, {24'h0, e});
    endtask : chk

    // Pick one pulse output by number
    function automatic logic pick(input int s);
        case (s)
            0: return dspTick;
            1: return modTick;
            2: return fsTick;
            3: return bclkOut;
            default: return gpioOut;
        endcase
    endfunction : pick

    // The first interval after a change may be partial, so the third is measured
    task automatic measure(input int s, input int exp);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (pick(s) !== 1'b1 && n < 4000);
        end
        check_per(n, exp);
    endtask : measure

    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Watchdog sized well above the expected run
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        $display("wrong value at %0t: timeout", $time);
        finish_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset factors on the PLL port and in the registers
        check_reg({4'h0, pllCfg}, {4'h0, 1'b0, 3'h1, 4'h1, 6'h04, 14'h0000});
        chk(IDX_PLL_CTRL, 8'h11);
        chk(IDX_PLL_J, 8'h04);
        chk(IDX_FRAC_LO, 8'h00);
        chk(IDX_NDIV, 8'h01);
        chk(IDX_OSR_LO, 8'h80);
        // Unmapped place reads zero with an OKAY answer
        wr(6'h00, 8'h5A);
        chk(6'h00, 8'h00);
        check_reg({31'h0, hresp}, 32'h0);
        // Status flags ignore writes
        wr(IDX_PWR_STAT, 8'hFF);
        chk(IDX_PWR_STAT, 8'h00);
        // P and R fields reach the PLL
        wr(IDX_PLL_CTRL, 8'h23);
        wr(IDX_PLL_J, 8'h3F);
        repeat (2) @(posedge clk);
        check_reg({24'h0, pllCfg.en, pllCfg.p, pllCfg.r}, 32'h23);
        check_reg({26'h0, pllCfg.j}, 32'h3F);
        chk(IDX_PLL_J, 8'h3F);
        // Fraction takes effect only with its lower half
        wr(IDX_FRAC_HI, 8'h1A);
        repeat (2) @(posedge clk);
        check_reg({18'h0, pllCfg.d}, 32'h0);
        wr(IDX_FRAC_LO, 8'h5C);
        repeat (2) @(posedge clk);
        check_reg({18'h0, pllCfg.d}, 32'h1A5C);
        chk(IDX_FRAC_HI, 8'h1A);
        wr(IDX_FRAC_HI, 8'h00);
        wr(IDX_FRAC_LO, 8'h00);
        wr(IDX_PLL_CTRL, 8'h91);
        @(posedge clk);
        check_reg({31'h0, pllCfg.en}, 32'h1);
        check_reg({31'h0, pllReady}, 32'h0);
        repeat (LOCK + 4) @(posedge clk);
        check_reg({31'h0, pllReady}, 32'h1);
        // Dividers N=2, M=2, OSR=4
        // Derived clocks far below limits
        wr(IDX_NDIV, 8'h82);
        wr(IDX_MDIV, 8'h82);
        wr(IDX_OSR_HI, 8'h00);
        wr(IDX_OSR_LO, 8'h04);
        // Each root source gives its own DSP period
        // Plain pins before PLL
        for (int s = 0; s < 4; s++) begin
            wr(IDX_ROOT_SEL, 8'(s));
            measure(0, (8 + 2 * s) * 2);
        end
        wr(IDX_ROOT_SEL, 8'h00);
        measure(1, 32);
        measure(2, 128);
        // Modulator divider of one passes every DSP tick
        wr(IDX_MDIV, 8'h81);
        measure(1, 16);
        wr(IDX_MDIV, 8'h82);
        // Bit clock by 3 from the DSP or modulator clock
        // Divider sources stay slow
        wr(IDX_PIN_CTRL, 8'h09);
        wr(IDX_B_DIV, 8'h03);
        check_reg({30'h0, bclkOe_n, gpioOe_n}, 32'h0);
        wr(IDX_B_SEL, 8'h00);
        measure(3, 48);
        wr(IDX_B_SEL, 8'h01);
        measure(3, 96);
        // GP clock by 2 from each source, then by 128 from the root
        wr(IDX_GP_DIV, 8'h02);
        for (int s = 0; s < 5; s++) begin
            wr(IDX_GP_SEL, 8'(s));
            measure(4, gpExp[s]);
        end
        wr(IDX_GP_SEL, 8'h00);
        wr(IDX_GP_DIV, 8'h00);
        measure(4, 1024);
        // Power up, then shutdown with the dividers kept running
        wr(IDX_PWR_CTRL, 8'h80);
        // Flags rise one cycle after the request lands
        @(posedge clk);
        chk(IDX_PWR_STAT, 8'h88);
        wr(IDX_PWR_CTRL, 8'h00);
        sawHalf = 1'b0;
        for (int k = 0; k < 300; k++) begin
            bus(IDX_PWR_STAT, 1'b0, 32'h0, rd);
            if (rd === 32'h08) begin
                sawHalf = 1'b1;
            end
            if (rd === 32'h0) begin
                break;
            end
        end
        check_reg(rd, 32'h0);
        check_reg({31'h0, sawHalf}, 32'h1);
        // Child divider off before its parent
        wr(IDX_MDIV, 8'h02);
        wr(IDX_NDIV, 8'h02);
        finish_test();
    end
endmodule : test_act_clock_tree
